// ==== lcd_cmd_pkg.sv ====
package lcd_cmd_pkg;
  // Register map, byte addresses
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_STATE = 8'h0c;
  // Command codes and masks
  localparam logic [7:0] CMD_DISP = 8'hae;
  localparam logic [7:0] CMD_ADC = 8'ha0;
  localparam logic [7:0] CMD_STATIC = 8'ha4;
  localparam logic [7:0] CMD_DUTY = 8'ha8;
  localparam logic [7:0] CMD_DUTY1 = 8'haa;
  localparam logic [7:0] CMD_RMW = 8'he0;
  localparam logic [7:0] CMD_END = 8'hee;
  localparam logic [7:0] CMD_RESET = 8'he2;
  localparam logic [7:0] CMD_CLKSTOP = 8'he6;
  localparam logic [7:0] MASK_OPT = 8'hfe;
  localparam logic [7:0] CMD_LINE = 8'hc0;
  localparam logic [7:0] MASK_LINE = 8'he0;
  localparam logic [7:0] CMD_PAGE = 8'hb8;
  localparam logic [7:0] MASK_PAGE = 8'hf8;
  localparam logic [7:0] CMD_PWR = 8'hb0;
  localparam logic [7:0] MASK_PWR = 8'hf8;
  localparam logic [7:0] CMD_CONTRAST = 8'h80;
  localparam logic [7:0] MASK_CONTRAST = 8'he0;
  // Field widths
  localparam int LINE_W = 5;
  localparam int PAGE_W = 3;
  localparam int COL_W = 7;
  localparam int PWR_W = 3;
  localparam int CON_W = 5;
  // Reset values
  localparam logic [LINE_W-1:0] LINE_RST = 5'h00;
  localparam logic [PAGE_W-1:0] PAGE_RST = 3'h0;
  localparam logic [COL_W-1:0] COL_RST = 7'h00;
  localparam logic [CON_W-1:0] CON_RST = 5'h00;
  localparam logic [PWR_W-1:0] PWR_RST = 3'h0;
  // Status bit positions
  localparam int ST_BUSY = 7;
  localparam int ST_ADC = 6;
  localparam int ST_ON = 5;
  localparam int ST_RST = 4;
  localparam int ST_PSAVE = 3;
  // Bus response
  typedef enum logic [1:0] {BS_IDLE = 2'b01, BS_DATA = 2'b10} bus_state_t;
  // Operating settings
  typedef struct packed {
    logic disp_on;
    logic adc_rev;
    logic static_on;
    logic duty_hi;
    logic duty_plus;
    logic clk_stop;
    logic rmw;
    logic psave;
    logic [PWR_W-1:0] pwr;
    logic [CON_W-1:0] contrast;
    logic [LINE_W-1:0] line;
    logic [PAGE_W-1:0] page;
    logic [COL_W-1:0] col;
    logic [COL_W-1:0] col_save;
  } settings_t;
endpackage : lcd_cmd_pkg

// ==== lcd_driver_command_decoder.sv ====
`timescale 1ns/1ns
module lcd_driver_command_decoder #(
  parameter int COLUMNS = 80,
  parameter int PAGES = 5,
  parameter int CLK_DIV = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Clocking
  input wire logic ext_clk_sel,
  input wire logic ext_clk_in,
  output logic display_clock_pin,
  // Panel and analog control
  output logic osc_enable,
  output logic scan_enable,
  output logic drivers_at_vdd,
  output logic follower_on,
  output logic regulator_on,
  output logic booster_on,
  output logic [lcd_cmd_pkg::CON_W-1:0] contrast_level,
  output logic [lcd_cmd_pkg::LINE_W-1:0] first_common_line,
  output logic seg_reversed,
  output logic all_pixels_on,
  output logic duty_high,
  output logic duty_plus_one
);
  initial begin
    if (COLUMNS < 1 || COLUMNS > 128 || PAGES < 1 || PAGES > 8 || CLK_DIV < 2 || CLK_DIV > 256)
      $error("Unsupported parameter value");
  end

  localparam int DEPTH = PAGES * 128;

  typedef struct packed {
    lcd_cmd_pkg::settings_t s;
    lcd_cmd_pkg::bus_state_t bst;
    logic wr;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic [7:0] div;
    logic clk_out;
  } state_t;

  state_t cur_r, cur_nxt;
  logic [7:0] ram [DEPTH];
  logic ram_we;
  logic [9:0] ram_idx;
  logic [7:0] ram_q;

  // Linear RAM index from page and column
  function automatic logic [9:0] ram_index(input logic [2:0] pg, input logic [6:0] cl);
    ram_index = {pg, cl};
  endfunction : ram_index

  // Column advance wraps at the panel width
  function automatic logic [6:0] col_inc(input logic [6:0] cl);
    col_inc = (cl == 7'(COLUMNS - 1)) ? 7'h00 : 7'(cl + 7'h01);
  endfunction : col_inc

  assign ram_idx = ram_index(cur_r.s.page, cur_r.s.col);
  assign ram_q = ram[ram_idx];

  // Decode, data-phase execution, clock divider
  always_comb begin
    logic [7:0] b;
    logic take;
    b = cur_r.wr ? hwdata[7:0] : 8'h00;
    cur_nxt = cur_r;
    ram_we = 1'b0;
    take = hsel && hready && htrans[1];
    // Data phase of a captured transfer
    if (cur_r.bst == lcd_cmd_pkg::BS_DATA) begin
      cur_nxt.bst = lcd_cmd_pkg::BS_IDLE;
      if (cur_r.wr && cur_r.addr == lcd_cmd_pkg::ADDR_CMD) begin
        if (!b[7]) begin
          cur_nxt.s.col = b[6:0];
        end else if ((b & lcd_cmd_pkg::MASK_OPT) == lcd_cmd_pkg::CMD_DISP) begin
          cur_nxt.s.disp_on = b[0];
          if (b[0])
            cur_nxt.s.psave = 1'b0;
        end else if ((b & lcd_cmd_pkg::MASK_OPT) == lcd_cmd_pkg::CMD_ADC) begin
          cur_nxt.s.adc_rev = b[0];
        end else if ((b & lcd_cmd_pkg::MASK_OPT) == lcd_cmd_pkg::CMD_STATIC) begin
          cur_nxt.s.static_on = b[0];
          if (b[0] && !cur_r.s.disp_on) begin
            cur_nxt.s.psave = 1'b1;
            cur_nxt.s.pwr = lcd_cmd_pkg::PWR_RST;
          end
          if (!b[0])
            cur_nxt.s.psave = 1'b0;
        end else if ((b & lcd_cmd_pkg::MASK_OPT) == lcd_cmd_pkg::CMD_DUTY) begin
          cur_nxt.s.duty_hi = b[0];
        end else if ((b & lcd_cmd_pkg::MASK_OPT) == lcd_cmd_pkg::CMD_DUTY1) begin
          cur_nxt.s.duty_plus = b[0];
        end else if ((b & lcd_cmd_pkg::MASK_OPT) == lcd_cmd_pkg::CMD_CLKSTOP) begin
          cur_nxt.s.clk_stop = b[0];
        end else if (b == lcd_cmd_pkg::CMD_RMW) begin
          cur_nxt.s.rmw = 1'b1;
          cur_nxt.s.col_save = cur_r.s.col;
        end else if (b == lcd_cmd_pkg::CMD_END) begin
          cur_nxt.s.rmw = 1'b0;
          cur_nxt.s.col = cur_r.s.col_save;
        end else if (b == lcd_cmd_pkg::CMD_RESET) begin
          cur_nxt.s.line = lcd_cmd_pkg::LINE_RST;
          cur_nxt.s.col = lcd_cmd_pkg::COL_RST;
          cur_nxt.s.page = lcd_cmd_pkg::PAGE_RST;
          cur_nxt.s.contrast = lcd_cmd_pkg::CON_RST;
        end else if ((b & lcd_cmd_pkg::MASK_LINE) == lcd_cmd_pkg::CMD_LINE) begin
          cur_nxt.s.line = b[4:0];
        end else if ((b & lcd_cmd_pkg::MASK_PAGE) == lcd_cmd_pkg::CMD_PAGE) begin
          cur_nxt.s.page = b[2:0];
        end else if ((b & lcd_cmd_pkg::MASK_PWR) == lcd_cmd_pkg::CMD_PWR) begin
          cur_nxt.s.pwr = b[2:0];
        end else if ((b & lcd_cmd_pkg::MASK_CONTRAST) == lcd_cmd_pkg::CMD_CONTRAST) begin
          cur_nxt.s.contrast = b[4:0];
        end
        // Undefined codes are dropped without effect
      end else if (cur_r.wr && cur_r.addr == lcd_cmd_pkg::ADDR_DATA) begin
        ram_we = 1'b1;
        cur_nxt.s.col = col_inc(cur_r.s.col);
      end else if (!cur_r.wr && cur_r.addr == lcd_cmd_pkg::ADDR_DATA) begin
        if (!cur_r.s.rmw)
          cur_nxt.s.col = col_inc(cur_r.s.col);
      end
    end
    // Address phase capture; read data is latched here for the data phase
    if (take) begin
      cur_nxt.bst = lcd_cmd_pkg::BS_DATA;
      cur_nxt.wr = hwrite;
      cur_nxt.addr = haddr;
      cur_nxt.rdata = 32'h0000_0000;
      if (!hwrite) begin
        case (haddr)
          lcd_cmd_pkg::ADDR_DATA: cur_nxt.rdata = {24'h00_0000, ram_q};
          lcd_cmd_pkg::ADDR_STATUS: begin
            cur_nxt.rdata[lcd_cmd_pkg::ST_ADC] = cur_r.s.adc_rev;
            cur_nxt.rdata[lcd_cmd_pkg::ST_ON] = cur_r.s.disp_on;
            cur_nxt.rdata[lcd_cmd_pkg::ST_PSAVE] = cur_r.s.psave;
          end
          lcd_cmd_pkg::ADDR_STATE: cur_nxt.rdata = {10'h000, cur_r.s.col, cur_r.s.page,
            cur_r.s.pwr, cur_r.s.contrast, cur_r.s.rmw, cur_r.s.duty_hi, cur_r.s.duty_plus,
            cur_r.s.static_on};
          default: cur_nxt.rdata = 32'h0000_0000;
        endcase
      end
    end else if (cur_r.bst == lcd_cmd_pkg::BS_DATA) begin
      cur_nxt.rdata = cur_r.rdata;
    end
    // Display clock divider; cleared and held low in power save, external clock ignored there
    if (cur_r.s.psave) begin
      cur_nxt.div = 8'h00;
      cur_nxt.clk_out = 1'b0;
    end else if (ext_clk_sel) begin
      cur_nxt.div = 8'h00;
      cur_nxt.clk_out = ext_clk_in;
    end else if (cur_r.div == 8'(CLK_DIV / 2 - 1)) begin
      cur_nxt.div = 8'h00;
      cur_nxt.clk_out = !cur_r.clk_out;
    end else begin
      cur_nxt.div = 8'(cur_r.div + 8'h01);
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cur_r <= '{s: '0, bst: lcd_cmd_pkg::BS_IDLE, wr: 1'b0, addr: 8'h00, rdata: 32'h0000_0000,
        div: 8'h00, clk_out: 1'b0};
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // Display RAM survives power save and the reset command
  always_ff @(posedge clk_sys) begin
    if (ram_we)
      ram[ram_idx] <= hwdata[7:0];
  end

  // Bus answers with zero wait states
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = cur_r.rdata;

  // Panel side outputs
  assign osc_enable = !cur_r.s.psave;
  assign scan_enable = !cur_r.s.psave;
  assign drivers_at_vdd = cur_r.s.psave;
  assign display_clock_pin = cur_r.clk_out && !cur_r.s.clk_stop;
  assign follower_on = cur_r.s.pwr[0] && !cur_r.s.psave;
  assign regulator_on = cur_r.s.pwr[1] && !cur_r.s.psave;
  assign booster_on = cur_r.s.pwr[2] && !cur_r.s.psave;
  assign contrast_level = cur_r.s.contrast;
  assign first_common_line = cur_r.s.line;
  assign seg_reversed = cur_r.s.adc_rev;
  assign all_pixels_on = cur_r.s.static_on && cur_r.s.disp_on;
  assign duty_high = cur_r.s.duty_hi;
  assign duty_plus_one = cur_r.s.duty_plus;

  // Checks
  AST_PSAVE_ENTRY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cur_r.bst == lcd_cmd_pkg::BS_DATA && cur_r.wr && cur_r.addr == lcd_cmd_pkg::ADDR_CMD
     && hwdata[7:0] == 8'ha5 && !cur_r.s.disp_on) |=> (drivers_at_vdd && cur_r.s.pwr == 3'h0))
    else $error("power save not entered");
  AST_PSAVE_CLK: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cur_r.s.psave |=> !display_clock_pin) else $error("clock active in power save");
  AST_PSAVE_OSC: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cur_r.s.psave |-> (!osc_enable && !booster_on && !regulator_on && !follower_on))
    else $error("power circuits active in power save");
  AST_COL_SET: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cur_r.bst == lcd_cmd_pkg::BS_DATA && cur_r.wr && cur_r.addr == lcd_cmd_pkg::ADDR_CMD
     && !hwdata[7]) |=> cur_r.s.col == $past(hwdata[6:0])) else $error("column not loaded");
  AST_RMW_READ: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cur_r.bst == lcd_cmd_pkg::BS_DATA && !cur_r.wr && cur_r.addr == lcd_cmd_pkg::ADDR_DATA
     && cur_r.s.rmw) |=> $stable(cur_r.s.col)) else $error("column moved on rmw read");
  AST_WRITE_INC: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cur_r.bst == lcd_cmd_pkg::BS_DATA && cur_r.wr && cur_r.addr == lcd_cmd_pkg::ADDR_DATA
     && cur_r.s.col == 7'h00) |=> cur_r.s.col == 7'h01) else $error("no increment");
  AST_DISP_ON: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cur_r.bst == lcd_cmd_pkg::BS_DATA && cur_r.wr && cur_r.addr == lcd_cmd_pkg::ADDR_CMD
     && hwdata[7:0] == 8'haf) |=> (cur_r.s.disp_on && !cur_r.s.psave))
    else $error("display on ignored");
  AST_STATUS_LOW: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (hsel && hready && htrans[1] && !hwrite && haddr == lcd_cmd_pkg::ADDR_STATUS)
    |=> hrdata[2:0] == 3'h0) else $error("status low bits set");
endmodule : lcd_driver_command_decoder

// ==== host_bus_model.sv ====
`timescale 1ns/1ns
// Host processor on the register bus; sends only defined command bytes
module host_bus_model (
  // Clock
  input wire logic clk_sys,
  // Slave answer
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Master request
  output logic hsel,
  output logic [7:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
  end

  // Single word transfer, each phase held until hready
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'b00;
    // Reads get a changing pattern so stale data cannot pass
    hwdata <= wr ? wd : ~hwdata;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
  endtask : xfer
endmodule : host_bus_model

// ==== lcd_driver_command_decoder_tb.sv ====
`timescale 1ns/1ns
module lcd_driver_command_decoder_tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic ext_clk_sel = 1'b0;
  logic ext_clk_in = 1'b0;
  logic hsel, hwrite, hready, hreadyout, hresp, display_clock_pin, osc_enable, scan_enable, drivers_at_vdd;
  logic follower_on, regulator_on, booster_on, seg_reversed, all_pixels_on, duty_high, duty_plus_one;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [4:0] contrast_level, first_common_line, v;
  logic [7:0] d [0:2];
  logic [6:0] c;
  int mismatches = 0;
  int check_count = 0;
  int n;
  integer seed = 32'h4dfd;

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  always #2 clk_sys = ~clk_sys;
  // External clock keeps moving so a leak to the pin shows
  always @(posedge clk_sys) ext_clk_in <= ~ext_clk_in;

  lcd_driver_command_decoder u_lcd_driver_command_decoder (
    .clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp,
    .hrdata, .ext_clk_sel, .ext_clk_in, .display_clock_pin, .osc_enable, .scan_enable, .drivers_at_vdd,
    .follower_on, .regulator_on, .booster_on, .contrast_level, .first_common_line, .seg_reversed,
    .all_pixels_on, .duty_high, .duty_plus_one
  );

  host_bus_model u_host_bus_model (
    .clk_sys, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Outputs are looked at 1 ns after the edge that applies a command
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] b);
    u_host_bus_model.xfer(wr, a, {24'h0, b}, rd);
    #1;
  endtask : bus

  task automatic cmd(input logic [7:0] b);
    bus(1'b1, lcd_cmd_pkg::ADDR_CMD, b);
  endtask : cmd

  task automatic rdreg(input logic [7:0] a);
    bus(1'b0, a, 8'h00);
  endtask : rdreg

  function automatic logic [31:0] st(input logic on, input logic rev, input logic ps);
    return {24'h0, 1'b0, rev, on, 1'b0, ps, 3'b000};
  endfunction : st

  // Counts pin changes over 16 cycles
  task automatic toggles();
    logic p;
    n = 0;
    repeat (16) begin
      p = display_clock_pin;
      @(posedge clk_sys);
      #1;
      if (display_clock_pin !== p) n++;
    end
  endtask : toggles

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run

  initial begin
    #100000;
    mismatches++;
    complete_run();
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    rdreg(lcd_cmd_pkg::ADDR_STATE);
    check(rd, 32'h0);
    check({osc_enable, scan_enable, drivers_at_vdd}, 3'b110);
    check({hreadyout, hresp}, 2'b10);
    // Panel on, segment order, mode bits
    cmd(8'haf);
    rdreg(lcd_cmd_pkg::ADDR_STATUS);
    check(rd, st(1'b1, 1'b0, 1'b0));
    cmd(8'ha1);
    rdreg(lcd_cmd_pkg::ADDR_STATUS);
    check({seg_reversed, rd}, {1'b1, st(1'b1, 1'b1, 1'b0)});
    cmd(8'ha5);
    cmd(8'ha9);
    cmd(8'hab);
    check({all_pixels_on, duty_high, duty_plus_one}, 3'b111);
    cmd(8'ha0);
    cmd(8'ha4);
    cmd(8'ha8);
    cmd(8'haa);
    check({seg_reversed, all_pixels_on, duty_high, duty_plus_one}, 4'b0000);
    // Random address and level fields
    for (int i = 0; i < 6; i++) begin
      v = 5'($random(seed));
      c = 7'($random(seed));
      cmd(lcd_cmd_pkg::CMD_LINE | {3'h0, v});
      check(first_common_line, v);
      cmd(lcd_cmd_pkg::CMD_CONTRAST | {3'h0, v});
      check(contrast_level, v);
      cmd(lcd_cmd_pkg::CMD_PWR | {5'h0, v[2:0]});
      check({booster_on, regulator_on, follower_on}, v[2:0]);
      cmd(lcd_cmd_pkg::CMD_PAGE | {5'h0, v[4:2]});
      cmd({1'b0, c});
      rdreg(lcd_cmd_pkg::ADDR_STATE);
      check(rd[21:9], {c, v[4:2], v[2:0]});
    end
    // Display data with auto increment and a dummy read
    c = 7'($unsigned($random(seed)) % 70);
    cmd(8'hba);
    cmd({1'b0, c});
    for (int i = 0; i < 3; i++) begin
      d[i] = 8'($random(seed));
      bus(1'b1, lcd_cmd_pkg::ADDR_DATA, d[i]);
    end
    rdreg(lcd_cmd_pkg::ADDR_STATE);
    check(rd[21:15], c + 7'd3);
    cmd({1'b0, c});
    rdreg(lcd_cmd_pkg::ADDR_DATA);
    rdreg(lcd_cmd_pkg::ADDR_DATA);
    check(rd[7:0], d[1]);
    rdreg(lcd_cmd_pkg::ADDR_DATA);
    check(rd[7:0], d[2]);
    // Read-modify-write keeps column on reads, restores on end
    cmd({1'b0, c});
    cmd(lcd_cmd_pkg::CMD_RMW);
    rdreg(lcd_cmd_pkg::ADDR_DATA);
    rdreg(lcd_cmd_pkg::ADDR_STATE);
    check({rd[21:15], rd[3]}, {c, 1'b1});
    bus(1'b1, lcd_cmd_pkg::ADDR_DATA, ~d[0]);
    rdreg(lcd_cmd_pkg::ADDR_STATE);
    check(rd[21:15], c + 7'd1);
    cmd(lcd_cmd_pkg::CMD_END);
    rdreg(lcd_cmd_pkg::ADDR_STATE);
    check({rd[21:15], rd[3]}, {c, 1'b0});
    // Reset command clears addresses but keeps RAM
    cmd(lcd_cmd_pkg::CMD_RESET);
    rdreg(lcd_cmd_pkg::ADDR_STATE);
    check({rd[21:12], rd[8:4], first_common_line}, 20'h0);
    cmd(8'hba);
    cmd({1'b0, c});
    rdreg(lcd_cmd_pkg::ADDR_DATA);
    rdreg(lcd_cmd_pkg::ADDR_DATA);
    check(rd[7:0], d[1]);
    // Clock stop on and off
    cmd(lcd_cmd_pkg::CMD_CLKSTOP | 8'h01);
    toggles();
    check(n, 0);
    cmd(lcd_cmd_pkg::CMD_CLKSTOP);
    toggles();
    check(n >= 4, 1'b1);
    // Static on with panel off enters power save
    cmd(8'h95);
    cmd(8'hb7);
    cmd(8'hae);
    cmd(8'ha5);
    ext_clk_sel <= 1'b1;
    check({osc_enable, scan_enable, drivers_at_vdd, all_pixels_on}, 4'b0010);
    toggles();
    check({n[7:0], display_clock_pin}, 9'h0);
    rdreg(lcd_cmd_pkg::ADDR_STATE);
    check({rd[11:4], rd[0], booster_on, regulator_on, follower_on}, {8'h15, 1'b1, 3'h0});
    check(contrast_level, 5'h15);
    ext_clk_sel <= 1'b0;
    cmd(8'ha4);
    check({osc_enable, scan_enable, drivers_at_vdd}, 3'b110);
    // Host sets power control again after leaving
    cmd(8'hb5);
    check({booster_on, regulator_on, follower_on}, 3'b101);
    cmd(8'ha5);
    check(drivers_at_vdd, 1'b1);
    cmd(8'haf);
    check({osc_enable, scan_enable, drivers_at_vdd, all_pixels_on}, 4'b1101);
    complete_run();
  end
endmodule : lcd_driver_command_decoder_tb
